// file: rtl/fbes_pkg.sv
`default_nettype none
package fbes_pkg;
	// ****************************************************************
	// event codes and qualifiers
	// ****************************************************************
	localparam logic [7:0] EVT_XLATE = 8'h82;
	localparam logic [7:0] EVT_QFULL = 8'h83;
	localparam logic [7:0] EVT_FSTALL = 8'h86;
	localparam logic [7:0] EVT_SLOWLD = 8'h87;
	localparam logic [7:0] EVT_BR_EXEC = 8'h88;
	localparam logic [7:0] EVT_BR_MISP = 8'h89;
	localparam logic [7:0] EVT_BR_DEC_MISP = 8'h8A;
	localparam logic [7:0] EVT_CND_EXEC = 8'h8B;
	localparam logic [7:0] EVT_CND_MISP = 8'h8C;
	localparam logic [7:0] EVT_IND_EXEC = 8'h8D;
	localparam logic [7:0] QUAL_FLUSH = 8'h40;
	localparam logic [7:0] QUAL_MISS_ALL = 8'h12;
	localparam logic [7:0] QUAL_MISS_SMALL = 8'h02;
	localparam logic [7:0] QUAL_MISS_LARGE = 8'h10;
	localparam logic [7:0] QUAL_QFULL = 8'h02;
	localparam logic [7:0] QUAL_NONE = 8'h00;
	// ****************************************************************
	// length decoder
	// ****************************************************************
	localparam logic [7:0] PFX_OPSIZE = 8'h66;
	localparam logic [7:0] PFX_ADSIZE = 8'h67;
	localparam int SLOW_DECODE_CYCLES = 6;
	localparam logic [2:0] SLOW_CNT_LAST = 3'h5;
	localparam logic [2:0] SLOW_CNT_RST = 3'h0;
	typedef enum logic [1:0] {MODE_REAL, MODE_BIG_REAL, MODE_PROT16, MODE_PROT32} fbes_mode_t;
	typedef enum {LD_IDLE, LD_SLOW} fbes_ld_state_t;
endpackage : fbes_pkg
`default_nettype wire

// file: rtl/fbes_ld_if.sv
`default_nettype none
interface fbes_ld_if;
	logic instr_valid;
	logic [7:0] prefix;
	logic has_imm;
	logic has_modrm;
	fbes_pkg::fbes_mode_t mode;
	logic done;
	logic slow_busy;
	modport ld (input instr_valid, prefix, has_imm, has_modrm, mode, output done, slow_busy);
	modport sel (output instr_valid, prefix, has_imm, has_modrm, mode, input done, slow_busy);
endinterface : fbes_ld_if
`default_nettype wire

// file: rtl/fbes_length_decoder.sv
`default_nettype none
module fbes_length_decoder (
	input wire logic core_clk,
	input wire logic rst_n,
	fbes_ld_if.ld ld
);
	import fbes_pkg::*;
	fbes_ld_state_t state_ff;
	fbes_ld_state_t nxt_state;
	logic [2:0] cnt_ff;
	logic [2:0] nxt_cnt;
	wire logic opsize_slow;
	wire logic adsize_slow;
	wire logic need_slow;
	wire logic start;

	// ****************************************************************
	// slow path select
	// ****************************************************************
	assign opsize_slow = (ld.prefix == PFX_OPSIZE) && ld.has_imm;
	wire logic mode_affected;
	// all four modes take the slow path; the set stays explicit should more modes appear
	assign mode_affected = ld.mode inside {MODE_REAL, MODE_BIG_REAL, MODE_PROT16, MODE_PROT32};
	assign adsize_slow = (ld.prefix == PFX_ADSIZE) && ld.has_modrm && mode_affected;
	assign need_slow = opsize_slow || adsize_slow;
	assign start = ld.instr_valid && (state_ff == LD_IDLE);
	assign ld.slow_busy = (state_ff == LD_SLOW);
	// fast instructions finish in the cycle they arrive
	assign ld.done = (start && !need_slow) || (ld.slow_busy && cnt_ff == SLOW_CNT_LAST);

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			LD_IDLE: begin
				if (start && need_slow) begin
					nxt_state = LD_SLOW;
					nxt_cnt = SLOW_CNT_RST;
				end
			end
			LD_SLOW: begin
				if (cnt_ff == SLOW_CNT_LAST) begin
					nxt_state = LD_IDLE;
				end else begin
					nxt_cnt = cnt_ff + 3'h1;
				end
			end
			default: nxt_state = LD_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= LD_IDLE;
			cnt_ff <= SLOW_CNT_RST;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	AST_SLOW_SIX: assert property (@(posedge core_clk) disable iff (!rst_n)
		(start && need_slow) |=> ld.slow_busy [*6] ##1 !ld.slow_busy)
		else $error("slow decode did not last six cycles");
	AST_FAST_ONE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(start && !need_slow) |-> ld.done ##1 !ld.slow_busy)
		else $error("fast decode not single cycle");
	AST_OPSIZE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(start && ld.prefix == PFX_OPSIZE && ld.has_imm) |=> ld.slow_busy)
		else $error("operand prefix with immediate not slow");
	AST_ADSIZE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(start && ld.prefix == PFX_ADSIZE && ld.has_modrm) |=> ld.slow_busy)
		else $error("address prefix with modrm not slow");
	COV_SLOW: cover property (@(posedge core_clk) disable iff (!rst_n) start && need_slow);
endmodule : fbes_length_decoder
`default_nettype wire

// file: rtl/fbes_event_select.sv
`default_nettype none
module fbes_event_select (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] evt_code,
	input wire logic [7:0] evt_qual,
	input wire logic xlate_flush,
	input wire logic xlate_small_miss,
	input wire logic xlate_large_miss,
	input wire logic instr_queue_full,
	input wire logic fetch_req,
	input wire logic fetch_cache_miss,
	input wire logic fetch_xlate_fault,
	input wire logic instr_valid,
	input wire logic [7:0] instr_prefix,
	input wire logic instr_has_imm,
	input wire logic instr_has_modrm,
	input wire fbes_pkg::fbes_mode_t cpu_mode,
	input wire logic br_exec,
	input wire logic br_is_uop,
	input wire logic br_mispredict,
	input wire logic br_decode_mispredict,
	input wire logic br_cond,
	input wire logic br_indirect,
	output logic fetch_enable,
	output logic decode_ready,
	output logic decode_done,
	output logic count_inc
);
	import fbes_pkg::*;

	// ****************************************************************
	// length decoder
	// ****************************************************************
	fbes_ld_if ldi ();
	assign ldi.instr_valid = instr_valid;
	assign ldi.prefix = instr_prefix;
	assign ldi.has_imm = instr_has_imm;
	assign ldi.has_modrm = instr_has_modrm;
	assign ldi.mode = cpu_mode;
	fbes_length_decoder u_ld (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ld(ldi.ld)
	);
	assign decode_ready = !ldi.slow_busy;
	assign decode_done = ldi.done;

	// ****************************************************************
	// front end conditions
	// ****************************************************************
	// fetch holds off while the queue is full; no entry is lost
	assign fetch_enable = !instr_queue_full;
	wire logic arch_br;
	wire logic fetch_stall;
	assign arch_br = br_exec && !br_is_uop;
	assign fetch_stall = fetch_req && (fetch_cache_miss || xlate_small_miss
		|| xlate_large_miss || fetch_xlate_fault);

	// ****************************************************************
	// decode table
	// ****************************************************************
	wire logic sel_flush, sel_miss_all, sel_miss_small, sel_miss_large, sel_qfull;
	wire logic sel_fstall, sel_slowld, sel_br, sel_br_misp, sel_br_dec, sel_cnd;
	wire logic sel_cnd_misp, sel_ind;
	wire logic q0;
	assign q0 = (evt_qual == QUAL_NONE);
	assign sel_flush = evt_code == EVT_XLATE && evt_qual == QUAL_FLUSH;
	assign sel_miss_all = evt_code == EVT_XLATE && evt_qual == QUAL_MISS_ALL;
	assign sel_miss_small = evt_code == EVT_XLATE && evt_qual == QUAL_MISS_SMALL;
	assign sel_miss_large = evt_code == EVT_XLATE && evt_qual == QUAL_MISS_LARGE;
	assign sel_qfull = evt_code == EVT_QFULL && evt_qual == QUAL_QFULL;
	assign sel_fstall = evt_code == EVT_FSTALL && q0;
	assign sel_slowld = evt_code == EVT_SLOWLD && q0;
	assign sel_br = evt_code == EVT_BR_EXEC && q0;
	assign sel_br_misp = evt_code == EVT_BR_MISP && q0;
	assign sel_br_dec = evt_code == EVT_BR_DEC_MISP && q0;
	assign sel_cnd = evt_code == EVT_CND_EXEC && q0;
	assign sel_cnd_misp = evt_code == EVT_CND_MISP && q0;
	assign sel_ind = evt_code == EVT_IND_EXEC && q0;

	wire logic nxt_count_inc;
	// one-hot select; anything unlisted gives no increment
	assign nxt_count_inc = (sel_flush && xlate_flush)
		|| (sel_miss_all && (xlate_small_miss || xlate_large_miss))
		|| (sel_miss_small && xlate_small_miss)
		|| (sel_miss_large && xlate_large_miss)
		|| (sel_qfull && instr_queue_full)
		|| (sel_fstall && fetch_stall)
		|| (sel_slowld && ldi.slow_busy)
		|| (sel_br && arch_br)
		|| (sel_br_misp && arch_br && br_mispredict)
		|| (sel_br_dec && arch_br && br_decode_mispredict)
		|| (sel_cnd && arch_br && br_cond)
		|| (sel_cnd_misp && arch_br && br_cond && br_mispredict)
		|| (sel_ind && arch_br && br_indirect);

	// registered so the counters see a clean pulse, one cycle after the cause
	logic count_inc_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_inc_ff <= 1'b0;
		end else begin
			count_inc_ff <= nxt_count_inc;
		end
	end
	assign count_inc = count_inc_ff;

	// ****************************************************************
	// checks
	// ****************************************************************
	AST_FLUSH: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_flush && xlate_flush) |=> count_inc)
		else $error("flush not counted");
	AST_MISS_ALL: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_miss_all && (xlate_small_miss || xlate_large_miss)) |=> count_inc)
		else $error("fetch miss not counted");
	AST_MISS_SMALL: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_miss_small && !xlate_small_miss) |=> !count_inc)
		else $error("small-page count without small miss");
	AST_QFULL: assert property (@(posedge core_clk) disable iff (!rst_n)
		sel_qfull |=> (count_inc == $past(instr_queue_full)))
		else $error("queue full cycle count wrong");
	AST_FETCH_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		instr_queue_full |-> !fetch_enable)
		else $error("fetch enabled while queue full");
	AST_FSTALL: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_fstall && fetch_req && fetch_xlate_fault) |=> count_inc)
		else $error("fault stall not counted");
	AST_SLOWLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_slowld && instr_valid && decode_ready && instr_prefix == PFX_OPSIZE
		&& instr_has_imm) ##1 sel_slowld |=> count_inc)
		else $error("slow decode cycle not counted");
	AST_UOP_BR: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_br && br_is_uop) |=> !count_inc)
		else $error("micro-op branch counted");
	AST_CND_MISP: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_cnd_misp && !(br_cond && br_mispredict)) |=> !count_inc)
		else $error("conditional mispredict counted wrongly");
	AST_UNLISTED: assert property (@(posedge core_clk) disable iff (!rst_n)
		(evt_code == 8'h84) |=> !count_inc)
		else $error("increment on unlisted code");
	AST_NO_FLUSH: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_flush && !xlate_flush) |=> !count_inc)
		else $error("flush count without flush");
	AST_MISS_NONE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_miss_all && !xlate_small_miss && !xlate_large_miss) |=> !count_inc)
		else $error("fetch miss count without miss");
	AST_MISS_SMALL_HIT: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_miss_small && xlate_small_miss) |=> count_inc)
		else $error("small-page miss not counted");
	AST_MISS_LARGE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_miss_large && xlate_large_miss) |=> count_inc)
		else $error("large-page miss not counted");
	AST_MISS_LARGE_ONLY: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_miss_large && !xlate_large_miss) |=> !count_inc)
		else $error("large-page count without large miss");
	AST_FSTALL_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_fstall && !fetch_req) |=> !count_inc)
		else $error("stall counted with no fetch");
	AST_FSTALL_CACHE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_fstall && fetch_req && fetch_cache_miss) |=> count_inc)
		else $error("cache miss stall not counted");
	AST_SLOWLD_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_slowld && decode_ready) |=> !count_inc)
		else $error("slow decode counted while decoder idle");
	AST_BR_EXEC: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_br && br_exec && !br_is_uop) |=> count_inc)
		else $error("executed branch not counted");
	AST_NO_BR: assert property (@(posedge core_clk) disable iff (!rst_n)
		((sel_br || sel_br_misp || sel_br_dec || sel_cnd || sel_cnd_misp || sel_ind)
		&& !br_exec) |=> !count_inc)
		else $error("branch event counted with no branch");
	AST_BR_MISP: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_br_misp && arch_br) |=> (count_inc == $past(br_mispredict)))
		else $error("mispredicted branch count wrong");
	AST_BR_DEC: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_br_dec && arch_br) |=> (count_inc == $past(br_decode_mispredict)))
		else $error("decode mispredict count wrong");
	AST_CND: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_cnd && arch_br) |=> (count_inc == $past(br_cond)))
		else $error("conditional branch count wrong");
	AST_IND: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_ind && arch_br) |=> (count_inc == $past(br_indirect)))
		else $error("indirect branch count wrong");
	AST_QUAL_REJECT: assert property (@(posedge core_clk) disable iff (!rst_n)
		(evt_code >= EVT_FSTALL && evt_code <= EVT_IND_EXEC && !q0) |=> !count_inc)
		else $error("increment on nonzero qualifier");

	// ****************************************************************
	// slow decode run length
	// ****************************************************************
	// independent of the decoder's own counter, so a stuck busy state is caught
	logic [2:0] slow_run_ff;
	wire logic [2:0] nxt_slow_run;
	assign nxt_slow_run = ldi.slow_busy ? slow_run_ff + 3'h1 : SLOW_CNT_RST;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			slow_run_ff <= SLOW_CNT_RST;
		end else begin
			slow_run_ff <= nxt_slow_run;
		end
	end
	AST_SLOW_RUN: assert property (@(posedge core_clk) disable iff (!rst_n)
		slow_run_ff <= 3'(SLOW_DECODE_CYCLES))
		else $error("slow decode ran past six cycles");
	AST_SLOW_END: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ldi.slow_busy && slow_run_ff == SLOW_CNT_LAST) |-> decode_done)
		else $error("slow decode did not finish in its sixth cycle");
	COV_CND_MISP: cover property (@(posedge core_clk) disable iff (!rst_n)
		sel_cnd_misp && arch_br && br_cond && br_mispredict);
	COV_BR: cover property (@(posedge core_clk) disable iff (!rst_n) sel_br && arch_br);
	COV_QFULL: cover property (@(posedge core_clk) disable iff (!rst_n) sel_qfull && instr_queue_full);
	COV_SLOWLD: cover property (@(posedge core_clk) disable iff (!rst_n) sel_slowld && ldi.slow_busy);
endmodule : fbes_event_select
`default_nettype wire

// file: sim/fbes_core_model.sv
`default_nettype none
module fbes_core_model
	import fbes_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic polite,
	input wire logic decode_ready,
	output var logic xlate_flush,
	output var logic xlate_small_miss,
	output var logic xlate_large_miss,
	output var logic instr_queue_full,
	output var logic fetch_req,
	output var logic fetch_cache_miss,
	output var logic fetch_xlate_fault,
	output var logic instr_valid,
	output var logic [7:0] instr_prefix,
	output var logic instr_has_imm,
	output var logic instr_has_modrm,
	output var fbes_pkg::fbes_mode_t cpu_mode,
	output var logic br_exec,
	output var logic br_is_uop,
	output var logic br_mispredict,
	output var logic br_decode_mispredict,
	output var logic br_cond,
	output var logic br_indirect
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] r;
	// ****************************************************************
	// random fetch, decode and branch activity, quiet during reset
	// ****************************************************************
	always @(negedge core_clk) begin
		r = rst_n ? $urandom : 32'h0;
		{xlate_flush, xlate_small_miss, xlate_large_miss, instr_queue_full} = r[3:0];
		{fetch_req, fetch_cache_miss, fetch_xlate_fault, instr_has_imm} = r[7:4];
		{instr_has_modrm, br_exec, br_is_uop, br_mispredict} = r[11:8];
		{br_decode_mispredict, br_cond, br_indirect} = r[14:12];
		// an impolite front end offers while the decoder is busy
		instr_valid = r[15] && (decode_ready || !polite);
		instr_prefix = (r[17:16] == 2'h0) ? 8'h66 : (r[17:16] == 2'h1) ? 8'h67 : r[31:24];
		cpu_mode = fbes_mode_t'(r[19:18]);
	end
endmodule : fbes_core_model
`default_nettype wire

// file: sim/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import fbes_pkg::*;
	logic core_clk, rst_n, polite;
	logic [7:0] evt_code, evt_qual, instr_prefix;
	logic xlate_flush, xlate_small_miss, xlate_large_miss, instr_queue_full, fetch_req;
	logic fetch_cache_miss, fetch_xlate_fault, instr_valid, instr_has_imm, instr_has_modrm;
	logic br_exec, br_is_uop, br_mispredict, br_decode_mispredict, br_cond, br_indirect;
	logic fetch_enable, decode_ready, decode_done, count_inc, exp_prev, slow, take;
	fbes_mode_t cpu_mode;
	int fails, tests_run, busy;
	logic [15:0] combos [21] = '{16'h8240, 16'h8212, 16'h8202, 16'h8210, 16'h8302, 16'h8600,
		16'h8700, 16'h8800, 16'h8900, 16'h8A00, 16'h8B00, 16'h8C00, 16'h8D00, 16'h8601,
		16'h8D01, 16'h8200, 16'h8300, 16'h8701, 16'h8E00, 16'h8100, 16'h8B02};
	fbes_event_select u_dut (.core_clk, .rst_n, .evt_code, .evt_qual, .xlate_flush,
		.xlate_small_miss, .xlate_large_miss, .instr_queue_full, .fetch_req, .fetch_cache_miss,
		.fetch_xlate_fault, .instr_valid, .instr_prefix, .instr_has_imm, .instr_has_modrm,
		.cpu_mode, .br_exec, .br_is_uop, .br_mispredict, .br_decode_mispredict, .br_cond,
		.br_indirect, .fetch_enable, .decode_ready, .decode_done, .count_inc);
	fbes_core_model u_core (.core_clk, .rst_n, .polite, .decode_ready, .xlate_flush,
		.xlate_small_miss, .xlate_large_miss, .instr_queue_full, .fetch_req, .fetch_cache_miss,
		.fetch_xlate_fault, .instr_valid, .instr_prefix, .instr_has_imm, .instr_has_modrm,
		.cpu_mode, .br_exec, .br_is_uop, .br_mispredict, .br_decode_mispredict, .br_cond,
		.br_indirect);
	// ****************************************************************
	// reference model of the selection table
	// ****************************************************************
	function automatic logic cond(input logic [15:0] sel);
		logic br;
		br = br_exec && !br_is_uop;
		case (sel)
			16'h8240: return xlate_flush;
			16'h8212: return xlate_small_miss || xlate_large_miss;
			16'h8202: return xlate_small_miss;
			16'h8210: return xlate_large_miss;
			16'h8302: return instr_queue_full;
			16'h8600: return fetch_req && (fetch_cache_miss || xlate_small_miss
				|| xlate_large_miss || fetch_xlate_fault);
			16'h8700: return busy > 0;
			16'h8800: return br;
			16'h8900: return br && br_mispredict;
			16'h8A00: return br && br_decode_mispredict;
			16'h8B00: return br && br_cond;
			16'h8C00: return br && br_cond && br_mispredict;
			16'h8D00: return br && br_indirect;
			default: return 1'b0;
		endcase
	endfunction : cond
	task automatic check(input logic seen, input logic exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic cycle(input logic [15:0] sel);
		@(negedge core_clk);
		{evt_code, evt_qual} <= sel;
		#1;
		check(count_inc, exp_prev);
		check(decode_ready, busy == 0);
		check(fetch_enable, !instr_queue_full);
		slow = (instr_prefix == 8'h66 && instr_has_imm)
			|| (instr_prefix == 8'h67 && instr_has_modrm);
		take = busy == 0 && instr_valid;
		check(decode_done, (take && !slow) || busy == 1);
		exp_prev = cond(sel);
		busy = (busy > 0) ? busy - 1 : ((take && slow) ? 6 : 0);
	endtask : cycle
	task automatic close_out();
		$display("comparisons=%0d mismatches=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out
	// ****************************************************************
	// stimulus
	// ****************************************************************
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		#60000;
		fails++;
		close_out();
	end
	initial begin
		rst_n = 1'b0;
		polite = 1'b1;
		evt_code = 8'h00;
		evt_qual = 8'h00;
		fails = 0;
		tests_run = 0;
		busy = 0;
		exp_prev = 1'b0;
		void'($urandom(67));
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		rst_n <= 1'b1;
		foreach (combos[i]) begin
			polite = i[0];
			repeat (60) cycle(combos[i]);
			$display("test code=%h qual=%h done", combos[i][15:8], combos[i][7:0]);
		end
		// a new random selection is drawn every cycle while events keep flowing
		for (int k = 0; k < 200; k++) begin
			cycle({4'h8, 4'($urandom_range(0, 15)), 8'($urandom_range(0, 2) * 8'h10 + 8'h02)});
		end
		$display("test random selection done");
		close_out();
	end
endmodule : testbench
`default_nettype wire
